// ---- rtl/adcc_ctrl.v ----
// conversion control with axi4-lite register slave
//
// Contract
// - sampling lengthened by extension field ticks
// - extension zero gives two-tick sampling
// - positive select: pins, ground, converter output
// - positive select: sensor, supplies, reference taps
// - negative select: pins, ground, converter output
// - selection changes wait for conversion end
// - stop one ends measurement, zero ignored
// - stop wins over simultaneous start
// - start one converts after running one
// - start reads one while busy, self-clears
// - continuous mode launched by one start
// - enabled event rising edge starts conversion
// - enable bits: window match, result done
// - completion compares result, sets window flag
// - window flag cleared by one, result read
// - completion sets result done flag
// - done flag cleared by one, result read
// - window mode codes off/below/above/inside/outside
// - continuous bit restarts after each completion
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_ctrl (
    input  wire        mclk,
    input  wire        nrst,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // converter side
    input  wire        conv_tick,
    input  wire        conv_done,
    input  wire [15:0] converted_value,
    input  wire [15:0] lower_threshold,
    input  wire [15:0] upper_threshold,
    input  wire        result_read,
    input  wire        event_in,
    output reg  [6:0]  pos_route,
    output reg  [6:0]  neg_route,
    output reg         route_valid,
    output reg         sampling,
    output reg         conv_go,
    output reg         conv_abort,
    output reg         irq
);

// *****
// states
// *****
localparam [2:0] ST_IDLE    = 3'b001;  // no conversion
localparam [2:0] ST_SAMPLE  = 3'b010;  // sampling phase
localparam [2:0] ST_CONVERT = 3'b100;  // waiting for core

// *****
// functions
// *****
// positive select code legal
function pos_code_ok;
    input [6:0] c;
    begin
        pos_code_ok = (c <= `ADCC_POS_PIN_LAST) ||
                      (c == `ADCC_SEL_GROUND) ||
                      (c == `ADCC_SEL_CONV_OUTPUT) ||
                      (c == `ADCC_SEL_TEMP_SENSOR) ||
                      (c == `ADCC_SEL_SUPPLY_TENTH) ||
                      (c == `ADCC_SEL_IO2_TENTH) ||
                      ((c >= `ADCC_SEL_TAP_FIRST) &&
                       (c <= `ADCC_SEL_TAP_LAST));
    end
endfunction

// negative select code legal
function neg_code_ok;
    input [6:0] c;
    begin
        neg_code_ok = (c <= `ADCC_NEG_PIN_LAST) ||
                      (c == `ADCC_SEL_GROUND) ||
                      (c == `ADCC_SEL_CONV_OUTPUT);
    end
endfunction

// window comparison of one result
function win_match;
    input [2:0]  m;
    input [15:0] r;
    input [15:0] lo;
    input [15:0] hi;
    begin
        case (m)
            `ADCC_WIN_BELOW:   win_match = (r < lo);
            `ADCC_WIN_ABOVE:   win_match = (r > hi);
            `ADCC_WIN_INSIDE:  win_match = (r >= lo) && (r <= hi);
            `ADCC_WIN_OUTSIDE: win_match = (r < lo) || (r > hi);
            default:           win_match = 1'b0;
        endcase
    end
endfunction

// *****
// registers and state
// *****
reg  [7:0]  sample_extension;     // extra sampling ticks
reg  [6:0]  positive_input_select; // software positive select
reg  [6:0]  negative_input_select; // software negative select
reg         continuous_conversion; // restart after each result
reg  [2:0]  window_mode;          // comparison mode
reg         event_start_enable;   // event input starts
reg  [1:0]  int_enable;           // interrupt enables
reg  [1:0]  int_flag;             // sticky flags
reg         start_pending;        // start waiting to run
reg  [2:0]  state;                // sequencer state
reg  [8:0]  sample_cnt;           // sampling ticks counted
reg         event_prev;           // event level last cycle
// write channel holding
reg         aw_hold;              // address taken
reg         w_hold;               // data taken
reg  [5:0]  wr_idx;               // write index
reg  [31:0] wr_data;              // write data
reg         wr_lane0;             // low byte lane enabled

wire        busy     = (state != ST_IDLE);
wire        wr_fire  = aw_hold & w_hold & ~s_axi_bvalid;
wire        cmd_wr   = wr_fire & wr_lane0 &
                       (wr_idx == `ADCC_IDX_COMMAND);
wire        stop_wr  = cmd_wr & wr_data[`ADCC_BIT_STOP];
wire        start_wr = cmd_wr & wr_data[`ADCC_BIT_START];
wire        flag_wr  = wr_fire & wr_lane0 &
                       (wr_idx == `ADCC_IDX_INT_FLAG);
wire        ev_rise  = event_in & ~event_prev;
wire        finish   = (state == ST_CONVERT) & conv_done;
wire [8:0]  sample_len = `ADCC_SAMPLE_BASE +
                         {1'b0, sample_extension};

// *****
// write channel
// *****
// address and data are taken in either order
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        aw_hold       <= 1'b0;
        w_hold        <= 1'b0;
        wr_idx        <= 6'h00;
        wr_data       <= 32'h0000_0000;
        wr_lane0      <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `ADCC_RESP_OKAY;
    end else begin
        // address handshake
        if (s_axi_awvalid & s_axi_awready) begin
            aw_hold       <= 1'b1;
            wr_idx        <= s_axi_awaddr[7:2];
            s_axi_awready <= 1'b0;
        end
        // data handshake
        if (s_axi_wvalid & s_axi_wready) begin
            w_hold       <= 1'b1;
            wr_data      <= s_axi_wdata;
            wr_lane0     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end
        // both held: store and answer
        if (wr_fire) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wr_idx)
                `ADCC_IDX_MODE_CTRL, `ADCC_IDX_WINDOW_MODE,
                `ADCC_IDX_SAMPLING_EXT, `ADCC_IDX_POS_SELECT,
                `ADCC_IDX_NEG_SELECT, `ADCC_IDX_COMMAND,
                `ADCC_IDX_EVENT_CTRL, `ADCC_IDX_INT_ENABLE,
                `ADCC_IDX_INT_FLAG: begin
                    s_axi_bresp <= `ADCC_RESP_OKAY;
                end
                default: begin
                    s_axi_bresp <= `ADCC_RESP_SLVERR;
                end
            endcase
        end
        // response taken: reopen both channels
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// *****
// configuration registers
// *****
// plain read/write fields, low byte lane only
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        sample_extension      <= `ADCC_RST_SAMPLING_EXT;
        positive_input_select <= `ADCC_RST_SELECT;
        negative_input_select <= `ADCC_RST_SELECT;
        continuous_conversion <= 1'b0;
        window_mode           <= `ADCC_RST_WINDOW_MODE;
        event_start_enable    <= 1'b0;
        int_enable            <= `ADCC_RST_FLAGS;
    end else if (wr_fire & wr_lane0) begin
        case (wr_idx)
            `ADCC_IDX_MODE_CTRL: begin
                continuous_conversion <=
                    wr_data[`ADCC_BIT_CONTINUOUS];
            end
            `ADCC_IDX_WINDOW_MODE: begin
                window_mode <= wr_data[2:0];
            end
            `ADCC_IDX_SAMPLING_EXT: begin
                sample_extension <= wr_data[7:0];
            end
            `ADCC_IDX_POS_SELECT: begin
                positive_input_select <= wr_data[6:0];
            end
            `ADCC_IDX_NEG_SELECT: begin
                negative_input_select <= wr_data[6:0];
            end
            `ADCC_IDX_EVENT_CTRL: begin
                event_start_enable <=
                    wr_data[`ADCC_BIT_EVENT_START];
            end
            `ADCC_IDX_INT_ENABLE: begin
                int_enable <= wr_data[1:0];
            end
            default: begin
                sample_extension <= sample_extension;
            end
        endcase
    end
end

// *****
// conversion sequencer
// *****
// start sources gather into one pending bit
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        state         <= ST_IDLE;
        start_pending <= 1'b0;
        sample_cnt    <= 9'h000;
        event_prev    <= 1'b0;
        pos_route     <= `ADCC_RST_SELECT;
        neg_route     <= `ADCC_RST_SELECT;
        route_valid   <= 1'b0;
        sampling      <= 1'b0;
        conv_go       <= 1'b0;
        conv_abort    <= 1'b0;
    end else begin
        event_prev <= event_in;
        conv_go    <= 1'b0;
        conv_abort <= 1'b0;
        if (stop_wr) begin
            // stop wins, nothing pending, no flags
            start_pending <= 1'b0;
            state         <= ST_IDLE;
            sampling      <= 1'b0;
            conv_abort    <= busy;
        end else begin
            // new start requests
            if (start_wr | (event_start_enable & ev_rise)) begin
                start_pending <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (start_pending) begin
                        // selection frozen for this conversion
                        pos_route   <= positive_input_select;
                        neg_route   <= negative_input_select;
                        route_valid <=
                            pos_code_ok(positive_input_select) &
                            neg_code_ok(negative_input_select);
                        start_pending <= 1'b0;
                        sample_cnt    <= 9'h000;
                        sampling      <= 1'b1;
                        state         <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    // two ticks plus the extension
                    if (conv_tick) begin
                        if (sample_cnt + 9'h001 >= sample_len) begin
                            sampling <= 1'b0;
                            conv_go  <= 1'b1;
                            state    <= ST_CONVERT;
                        end else begin
                            sample_cnt <= sample_cnt + 9'h001;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (conv_done) begin
                        // continuous mode needs no new command
                        if (continuous_conversion) begin
                            start_pending <= 1'b1;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
end

// *****
// interrupt flags
// *****
// hardware set wins over a clear in the same cycle
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        int_flag <= `ADCC_RST_FLAGS;
    end else begin
        if (flag_wr & wr_data[`ADCC_BIT_WINDOW_MATCH] |
            result_read) begin
            int_flag[`ADCC_BIT_WINDOW_MATCH] <= 1'b0;
        end
        if (flag_wr & wr_data[`ADCC_BIT_RESULT_DONE] |
            result_read) begin
            int_flag[`ADCC_BIT_RESULT_DONE] <= 1'b0;
        end
        if (finish & ~stop_wr) begin
            int_flag[`ADCC_BIT_RESULT_DONE] <= 1'b1;
            if (win_match(window_mode, converted_value,
                          lower_threshold, upper_threshold)) begin
                int_flag[`ADCC_BIT_WINDOW_MATCH] <= 1'b1;
            end
        end
    end
end

// interrupt request from enabled flags
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        irq <= 1'b0;
    end else begin
        irq <= |(int_flag & int_enable);
    end
end

// *****
// read channel
// *****
// one read at a time, data one cycle after address
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `ADCC_RESP_OKAY;
    end else begin
        if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `ADCC_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            case (s_axi_araddr[7:2])
                `ADCC_IDX_MODE_CTRL: begin
                    s_axi_rdata[`ADCC_BIT_CONTINUOUS] <=
                        continuous_conversion;
                end
                `ADCC_IDX_WINDOW_MODE: begin
                    s_axi_rdata[2:0] <= window_mode;
                end
                `ADCC_IDX_SAMPLING_EXT: begin
                    s_axi_rdata[7:0] <= sample_extension;
                end
                `ADCC_IDX_POS_SELECT: begin
                    s_axi_rdata[6:0] <= positive_input_select;
                end
                `ADCC_IDX_NEG_SELECT: begin
                    s_axi_rdata[6:0] <= negative_input_select;
                end
                `ADCC_IDX_COMMAND: begin
                    // stop reads zero, start shows activity
                    s_axi_rdata[`ADCC_BIT_START] <=
                        busy | start_pending;
                end
                `ADCC_IDX_EVENT_CTRL: begin
                    s_axi_rdata[`ADCC_BIT_EVENT_START] <=
                        event_start_enable;
                end
                `ADCC_IDX_INT_ENABLE: begin
                    s_axi_rdata[1:0] <= int_enable;
                end
                `ADCC_IDX_INT_FLAG: begin
                    s_axi_rdata[1:0] <= int_flag;
                end
                default: begin
                    s_axi_rresp <= `ADCC_RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule // adcc_ctrl
`default_nettype wire

// ---- shared/adcc_defs.vh ----
// register map, field positions, reset values and codes of the converter control
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// *****
// register indexes (byte address is four times the index)
// *****
`define ADCC_IDX_MODE_CTRL      6'h00
`define ADCC_IDX_WINDOW_MODE    6'h04
`define ADCC_IDX_SAMPLING_EXT   6'h05
`define ADCC_IDX_POS_SELECT     6'h08
`define ADCC_IDX_NEG_SELECT     6'h09
`define ADCC_IDX_COMMAND        6'h0a
`define ADCC_IDX_EVENT_CTRL     6'h0b
`define ADCC_IDX_INT_ENABLE     6'h0c
`define ADCC_IDX_INT_FLAG       6'h0d

// *****
// reset values
// *****
`define ADCC_RST_SAMPLING_EXT   8'h00
`define ADCC_RST_SELECT         7'h00
`define ADCC_RST_WINDOW_MODE    3'h0
`define ADCC_RST_FLAGS          2'h0

// *****
// field positions
// *****
`define ADCC_BIT_CONTINUOUS     1
`define ADCC_BIT_STOP           1
`define ADCC_BIT_START          0
`define ADCC_BIT_EVENT_START    0
`define ADCC_BIT_WINDOW_MATCH   1
`define ADCC_BIT_RESULT_DONE    0

// *****
// input select codes
// *****
`define ADCC_POS_PIN_LAST       7'h15
`define ADCC_NEG_PIN_LAST       7'h0f
`define ADCC_SEL_GROUND         7'h40
`define ADCC_SEL_TEMP_SENSOR    7'h42
`define ADCC_SEL_SUPPLY_TENTH   7'h44
`define ADCC_SEL_IO2_TENTH      7'h45
`define ADCC_SEL_CONV_OUTPUT    7'h48
`define ADCC_SEL_TAP_FIRST      7'h49
`define ADCC_SEL_TAP_LAST       7'h4b

// *****
// window modes
// *****
`define ADCC_WIN_OFF            3'h0
`define ADCC_WIN_BELOW          3'h1
`define ADCC_WIN_ABOVE          3'h2
`define ADCC_WIN_INSIDE         3'h3
`define ADCC_WIN_OUTSIDE        3'h4

// *****
// timing and bus answers
// *****
`define ADCC_SAMPLE_BASE        9'h002
`define ADCC_RESP_OKAY          2'h0
`define ADCC_RESP_SLVERR        2'h2

`endif

// ---- sim/adcc_checker.sv ----
// assertion checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
    input wire logic       mclk,
    input wire logic       nrst,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       conv_tick,
    input wire logic [6:0] pos_route,
    input wire logic [6:0] neg_route,
    input wire logic       route_valid,
    input wire logic       sampling,
    input wire logic       conv_go,
    input wire logic       conv_abort
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic [8:0] tk; // ticks counted in this sampling phase
    always @(posedge mclk or negedge nrst)
        if (!nrst) tk <= 9'h000;
        else if (!sampling) tk <= 9'h000;
        else if (conv_tick) tk <= tk + 9'h001;
    // legal codes of the two frozen selections
    wire logic pos_ok = (pos_route <= 7'h15) || (pos_route == 7'h40)
        || (pos_route == 7'h42) || (pos_route == 7'h44)
        || (pos_route == 7'h45) || (pos_route == 7'h48)
        || (pos_route >= 7'h49 && pos_route <= 7'h4b);
    wire logic neg_ok = (neg_route <= 7'h0f) || (neg_route == 7'h40)
        || (neg_route == 7'h48);
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_samp_end;
        sampling ##1 !sampling;
    endsequence
    property p_wr_resp; s_wr |-> ##2 s_axi_bvalid; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no read answer");
    property p_go_cause; conv_go |-> $past(sampling) && $past(conv_tick);
    endproperty
    a_go_cause: assert property (p_go_cause) else $error("stray go");
    property p_go_pulse; conv_go |=> !conv_go; endproperty
    a_go_pulse: assert property (p_go_pulse) else $error("go too long");
    property p_min_samp; conv_go |-> tk >= 9'h002; endproperty
    a_min_samp: assert property (p_min_samp) else $error("short sample");
    property p_route_hold;
        sampling && $past(sampling) |-> $stable(pos_route) && $stable(neg_route);
    endproperty
    a_route_hold: assert property (p_route_hold) else $error("route moved");
    property p_route_ok; sampling |-> route_valid == (pos_ok && neg_ok);
    endproperty
    a_route_ok: assert property (p_route_ok) else $error("bad legal flag");
    property p_abort; conv_abort |-> !conv_go && !sampling; endproperty
    a_abort: assert property (p_abort) else $error("abort went on");
    property p_samp_end; s_samp_end |-> conv_go || conv_abort; endproperty
    a_samp_end: assert property (p_samp_end) else $error("sample lost");
endmodule // adcc_checker
bind adcc_ctrl adcc_checker u_chk (.*);
`default_nettype wire

// ---- sim/adcc_core_model.sv ----
// stand-in for the converter core: tick divider, delayed completion
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        conv_go,
    input  wire logic        conv_abort,
    input  wire logic [3:0]  lat,
    input  wire logic [15:0] value,
    output logic             conv_tick,
    output logic             conv_done,
    output logic [15:0]      converted_value
);
    logic [1:0] div;  // converter clock divider
    logic [3:0] left; // cycles until completion
    assign conv_tick = (div == 2'h2);
    // result valid only with completion, inverted otherwise
    assign converted_value = conv_done ? value : ~value;
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div <= 2'h0;
            left <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            div <= conv_tick ? 2'h0 : div + 2'h1;
            conv_done <= (left == 4'h1) && !conv_abort;
            if (conv_abort) left <= 4'h0;
            else if (conv_go) left <= lat;
            else if (left != 4'h0) left <= left - 4'h1;
        end
    end
endmodule // adcc_core_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [5:0] sx_i = 6'h05, ps_i = 6'h08, cmd_i = 6'h0a;
    localparam logic [5:0] ev_i = 6'h0b, en_i = 6'h0c, fl_i = 6'h0d;
    logic        mclk = 0, nrst = 0, awvalid = 0, wvalid = 0, arvalid = 0;
    logic        rres = 0, evt = 0;           // result read, event line
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [15:0] value = 0, lo = 16'h0100, hi = 16'h0200; // result, window
    logic [3:0]  lat = 1, ws = 4'hf;           // core latency, strobes
    logic [33:0] rq[$], sq[$], tn = 0;         // expected reads, ticks
    logic [1:0]  bq[$];                        // expected write answers
    int          errors = 0, compares = 0, gn = 0;
    wire logic   awready, wready, bvalid, arready, rvalid, tick, done;
    wire logic   rv, samp, go, abt, irq;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [6:0]  pr, nr;
    wire logic [15:0] cv;
    always #10 mclk = ~mclk;
    adcc_ctrl dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .conv_tick(tick),
        .conv_done(done), .converted_value(cv), .lower_threshold(lo),
        .upper_threshold(hi), .result_read(rres), .event_in(evt),
        .pos_route(pr), .neg_route(nr), .route_valid(rv), .sampling(samp),
        .conv_go(go), .conv_abort(abt), .irq(irq));
    adcc_core_model u_core (.mclk(mclk), .nrst(nrst), .conv_go(go),
        .conv_abort(abt), .lat(lat), .value(value), .conv_tick(tick),
        .conv_done(done), .converted_value(cv));
    task automatic chk(string n, logic [33:0] s, logic [33:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        if (errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // bus write: address and data offered together, each released when taken
    task automatic wr(input [5:0] i, input [7:0] d, input [1:0] r = 2'h0);
        logic a = 1, w = 1;
        bq.push_back(r);
        awaddr <= {i, 2'h0};
        wdata <= {24'($urandom), d};
        ws <= {3'($urandom), 1'b1};
        awvalid <= 1;
        wvalid <= 1;
        forever begin
            @(posedge mclk);
            if (a && awready) begin a = 0; awvalid <= 0; end
            if (w && wready) begin w = 0; wvalid <= 0; end
            if (bvalid) return;
        end
    endtask
    task automatic rd(input [5:0] i, input [7:0] e, input [1:0] r = 2'h0);
        logic a = 1;
        rq.push_back({r, 24'h0, e});
        araddr <= {i, 2'h0};
        arvalid <= 1;
        forever begin
            @(posedge mclk);
            if (a && arready) begin a = 0; arvalid <= 0; end
            if (rvalid) return;
        end
    endtask
    task automatic pause(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic ev;
        evt <= 1;
        pause(2);
        evt <= 0;
        pause(2);
    endtask
    // watcher: answers against the oldest note, ticks per sampling phase
    always @(posedge mclk) begin
        if (rvalid) chk("read", {rresp, rdata}, rq.pop_front());
        if (bvalid) chk("bresp", 34'(bresp), 34'(bq.pop_front()));
        if (go) begin
            gn++;
            if (sq.size() > 0) chk("ticks", tn, sq.pop_front());
        end
        if (samp && tick) tn++;
        else if (!samp) tn = 0;
    end
    initial begin
        pause(20000);
        errors++;
        stop_test();
    end
    initial begin
        logic [5:0]  idx[9] = '{6'h00, 6'h04, sx_i, ps_i, 6'h09, cmd_i,
            ev_i, en_i, fl_i};
        logic [15:0] pick[4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
        logic [7:0]  d, x;
        logic [15:0] v;
        logic [1:0]  en;
        logic        mt;
        int          g0;
        void'($urandom(32'hdfc8));
        pause(5);
        nrst <= 1;
        pause(1);
        foreach (idx[k]) rd(idx[k], 8'h00);
        rd(6'h3f, 8'h00, 2'h2);
        wr(6'h3f, 8'hff, 2'h2);
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            wr(sx_i, d);
            rd(sx_i, d);
            wr(ps_i, {1'b0, d[6:0]});
            rd(ps_i, {1'b0, d[6:0]});
        end
        // every window mode, boundary results, both ways of clearing
        for (int k = 0; k < 10; k++) begin
            v = (k < 8) ? pick[k % 4] : 16'($urandom);
            case (k % 5)
                1: mt = v < 16'h0100;
                2: mt = v > 16'h0200;
                3: mt = v >= 16'h0100 && v <= 16'h0200;
                4: mt = v < 16'h0100 || v > 16'h0200;
                default: mt = 0;
            endcase
            x = 8'($urandom_range(3));
            en = 2'($urandom);
            wr(sx_i, x);
            wr(6'h04, 8'(k % 5));
            wr(en_i, {6'h0, en});
            wr(ps_i, 8'($urandom_range(8'h4b, 8'h40)));
            sq.push_back(34'(x) + 2);
            value <= v;
            lat <= 4'($urandom_range(12, 1));
            wr(cmd_i, 8'h01);
            rd(cmd_i, 8'h01);
            for (int t = 0; t < 300 && !done; t++) pause(1);
            pause(2);
            rd(cmd_i, 8'h00);
            wr(fl_i, 8'h00);
            rd(fl_i, {6'h0, mt, 1'b1});
            chk("irq", 34'(irq), 34'(|({mt, 1'b1} & en)));
            if (k % 2) wr(fl_i, 8'h03);
            else begin rres <= 1; pause(1); rres <= 0; end
            rd(fl_i, 8'h00);
            chk("irq", 34'(irq), 34'(0));
        end
        // stop in mid-sample, stop with start while idle
        g0 = gn;
        wr(sx_i, 8'h10);
        wr(cmd_i, 8'h01);
        wr(cmd_i, 8'h00);
        rd(cmd_i, 8'h01);
        wr(cmd_i, 8'h02);
        rd(cmd_i, 8'h00);
        wr(cmd_i, 8'h03);
        pause(200);
        rd(cmd_i, 8'h00);
        rd(fl_i, 8'h00);
        chk("stop", 34'(gn - g0), 34'(0));
        // start while busy is queued, new selection waits for completion
        wr(sx_i, 8'h00);
        wr(ps_i, 8'h15);
        sq.push_back(2);
        sq.push_back(2);
        wr(cmd_i, 8'h01);
        wr(ps_i, 8'h42);
        chk("route", 34'(pr), 34'(7'h15));
        wr(cmd_i, 8'h01);
        pause(100);
        chk("route", 34'(pr), 34'(7'h42));
        chk("queued", 34'(gn - g0), 34'(2));
        // event edges count only while enabled
        sq.push_back(2);
        ev();
        wr(ev_i, 8'h01);
        ev();
        pause(100);
        chk("event", 34'(gn - g0), 34'(3));
        // continuous conversion from one start, ended by stop
        wr(6'h00, 8'h02);
        rd(6'h00, 8'h02);
        wr(cmd_i, 8'h01);
        pause(200);
        wr(cmd_i, 8'h02);
        chk("free", 34'(gn - g0 > 6), 34'(1));
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
